// [core/periodic_timer.sv]
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
// Summary of operation
// RULE_01: mode field: 00 compare output, 10 pwm or single pulse, 11 timer; 01 undefined.
// RULE_02: software turns timer off before changing the mode field.
// RULE_03: in timer mode the output pin is not driven to a defined level.
// RULE_04: compare mode match A: 00 no change, 01 low, 10 high, 11 toggle.
// RULE_05: pwm mode: 00 inactive, 01 active, 10 pwm waveform, 11 single pulse.
// RULE_06: match requesting the initial level gives no visible pin change.
// RULE_07: counter on rising edge returns pin to its initial level.
// RULE_08: software changes pin function only while timer is off.
// RULE_09: compare mode level bit sets pin level before first match.
// RULE_10: pwm mode level bit picks active high or active low.
// RULE_11: single pulse level bit sets pin level at counter on rising edge.
// RULE_12: invert bit flips the pin; invert and level bits ignored in timer mode.
// RULE_13: software writes zero to reserved bit 1 of mode register.
// RULE_14: clear source 1 clears on match A; 0 on match P or overflow.
// RULE_15: overflow clears only with clear source 0 and compare P all zero.
// RULE_16: clear source has no effect in pwm or single pulse mode.
// RULE_17: 10-bit counter read-only, split over low and high registers.
// RULE_18: 10-bit compare A value read/write, split over low and high registers.
// RULE_19: 10-bit compare P value read/write, split over low and high registers.
// RULE_20: high register bits 7 to 2 read as zero.
// RULE_21: counter on rising edge clears counter; falling edge stops and keeps it.
// RULE_22: match when counter equals full 10-bit compare value, once per tick.
module periodic_timer
	import ptimer_pkg::*;
(
	// apb clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// timer output pin
	output logic timer_out_pin,
	output logic timer_out_oe_n
);

	////////////////////////////////////////////////////////////////////////////////
	// register state

	logic [7:0] ctrl0_reg;
	logic [7:0] ctrl0_next;
	logic [7:0] mode_reg;
	logic [7:0] mode_next;
	logic [CNT_W-1:0] cmpa_reg;
	logic [CNT_W-1:0] cmpa_next;
	logic [CNT_W-1:0] cmpp_reg;
	logic [CNT_W-1:0] cmpp_next;
	logic [PRESCALE_W-1:0] prescale_reg;
	logic [PRESCALE_W-1:0] prescale_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic on_prev_reg;
	logic on_prev_next;
	logic pin_reg;
	logic pin_next;
	logic oe_n_reg;
	logic oe_n_next;
	run_state_e run_reg;
	run_state_e run_next;

	mode_cfg_s cfg;
	cnt_event_s events;
	logic [CNT_W-1:0] count;
	logic tick;
	logic counter_on;
	logic start;
	logic access;
	logic auto_off;
	logic level;
	logic pwm_active;
	logic single_pulse;
	logic [CNT_W-1:0] cmpp_used;

	// address decode used by read and write paths
	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == ADDR_CTRL0) || (a == ADDR_MODE_CTRL) || (a == ADDR_CNT_LOW) ||
			(a == ADDR_CNT_HIGH) || (a == ADDR_CMPA_LOW) || (a == ADDR_CMPA_HIGH) ||
			(a == ADDR_CMPP_LOW) || (a == ADDR_CMPP_HIGH) || (a == ADDR_PRESCALE);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// field decode

	assign cfg.op_mode_sel = mode_reg[MODE_OP_LSB +: 2];
	assign cfg.pin_func_sel = mode_reg[MODE_PIN_LSB +: 2];
	assign cfg.out_level_ctrl = mode_reg[MODE_LEVEL_BIT];
	assign cfg.out_invert = mode_reg[MODE_INVERT_BIT];
	assign cfg.clear_source_sel = mode_reg[MODE_CLEAR_BIT];
	assign counter_on = ctrl0_reg[CTRL0_ON_BIT];
	assign start = counter_on && !on_prev_reg; // RULE_07 RULE_21
	assign access = psel && penable && !pready_reg;
	assign level = cfg.out_level_ctrl;

	////////////////////////////////////////////////////////////////////////////////
	// submodules

	timer_tick_gen #(
		.W(PRESCALE_W)
	) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.divide(prescale_reg),
		.tick(tick)
	);

	timer_counter10 u_cnt (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.start(start),
		.run(run_reg == RUN_ON),
		.op_mode(cfg.op_mode_sel),
		.clear_source_sel(cfg.clear_source_sel),
		.compare_a_value(cmpa_reg),
		.compare_p_value(cmpp_used),
		.count(count),
		.events(events)
	);

	////////////////////////////////////////////////////////////////////////////////
	// single pulse ends on a match A by dropping counter_on

	assign single_pulse = (cfg.op_mode_sel == OP_PWM) && (cfg.pin_func_sel == PIN_11);
	assign auto_off = single_pulse && events.match_a;
	// compare P plays no part in a single pulse, so it must not cut the count short
	assign cmpp_used = single_pulse ? CNT_RESET : cmpp_reg;

	// apb register writes and reads, one wait state
	always_comb
	begin
		ctrl0_next = ctrl0_reg;
		mode_next = mode_reg;
		cmpa_next = cmpa_reg;
		cmpp_next = cmpp_reg;
		prescale_next = prescale_reg;
		prdata_next = prdata_reg;
		pslverr_next = 1'b0;
		pready_next = access;
		if (access)
		begin
			pslverr_next = !addr_known(paddr);
			prdata_next = 32'h0000_0000;
			if (pwrite)
			begin
				unique case (paddr)
					ADDR_CTRL0: ctrl0_next = pwdata[7:0] & 8'h88;
					ADDR_MODE_CTRL: mode_next = pwdata[7:0]; // RULE_01 RULE_13
					ADDR_CMPA_LOW: cmpa_next[7:0] = pwdata[7:0]; // RULE_18
					ADDR_CMPA_HIGH: cmpa_next[9:8] = pwdata[1:0]; // RULE_18
					ADDR_CMPP_LOW: cmpp_next[7:0] = pwdata[7:0]; // RULE_19
					ADDR_CMPP_HIGH: cmpp_next[9:8] = pwdata[1:0]; // RULE_19
					ADDR_PRESCALE: prescale_next = pwdata[PRESCALE_W-1:0];
					default: ;
				endcase
			end
			else
			begin
				unique case (paddr)
					ADDR_CTRL0: prdata_next[7:0] = ctrl0_reg;
					ADDR_MODE_CTRL: prdata_next[7:0] = mode_reg;
					ADDR_CNT_LOW: prdata_next[7:0] = count[7:0]; // RULE_17
					ADDR_CNT_HIGH: prdata_next[1:0] = count[9:8]; // RULE_17 RULE_20
					ADDR_CMPA_LOW: prdata_next[7:0] = cmpa_reg[7:0];
					ADDR_CMPA_HIGH: prdata_next[1:0] = cmpa_reg[9:8]; // RULE_20
					ADDR_CMPP_LOW: prdata_next[7:0] = cmpp_reg[7:0];
					ADDR_CMPP_HIGH: prdata_next[1:0] = cmpp_reg[9:8]; // RULE_20
					ADDR_PRESCALE: prdata_next[PRESCALE_W-1:0] = prescale_reg;
					default: ;
				endcase
			end
		end
		// the pulse end wins over a software write in the same cycle
		if (auto_off)
			ctrl0_next[CTRL0_ON_BIT] = 1'b0;
	end

	// register file
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl0_reg <= CTRL_RESET;
			mode_reg <= CTRL_RESET;
			cmpa_reg <= CNT_RESET;
			cmpp_reg <= CNT_RESET;
			prescale_reg <= PRESCALE_RESET;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			ctrl0_reg <= ctrl0_next;
			mode_reg <= mode_next;
			cmpa_reg <= cmpa_next;
			cmpp_reg <= cmpp_next;
			prescale_reg <= prescale_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// run state: off, running, paused

	always_comb
	begin
		on_prev_next = counter_on;
		unique case (run_reg)
			RUN_OFF: run_next = counter_on ? RUN_ON : RUN_OFF;
			RUN_ON: run_next = !counter_on ? RUN_OFF : (ctrl0_reg[CTRL0_PAUSE_BIT] ? RUN_PAUSE : RUN_ON); // RULE_21
			RUN_PAUSE: run_next = !counter_on ? RUN_OFF : (ctrl0_reg[CTRL0_PAUSE_BIT] ? RUN_PAUSE : RUN_ON);
			default: run_next = RUN_OFF;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_reg <= RUN_OFF;
			on_prev_reg <= 1'b0;
		end
		else
		begin
			run_reg <= run_next;
			on_prev_reg <= on_prev_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output pin: pin_reg holds the level before inversion

	always_comb
	begin
		pin_next = pin_reg;
		oe_n_next = 1'b0;
		pwm_active = (count < cmpa_reg);
		unique case (cfg.op_mode_sel)
			OP_COMPARE:
			begin
				if (start)
					pin_next = level; // RULE_07 RULE_09
				else if (events.match_a)
				begin
					unique case (cfg.pin_func_sel) // RULE_04 RULE_06
						PIN_00: pin_next = pin_reg;
						PIN_01: pin_next = 1'b0;
						PIN_10: pin_next = 1'b1;
						PIN_11: pin_next = !pin_reg;
					endcase
				end
			end
			OP_PWM:
			begin
				unique case (cfg.pin_func_sel) // RULE_05
					PIN_00: pin_next = !level; // RULE_10
					PIN_01: pin_next = level; // RULE_10
					PIN_10: pin_next = (run_reg != RUN_OFF) && pwm_active ? level : !level; // RULE_10
					PIN_11: pin_next = counter_on ? level : !level; // RULE_11
				endcase
			end
			default:
			begin
				pin_next = 1'b0;
				oe_n_next = 1'b1; // RULE_03 RULE_12
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_reg <= 1'b0;
			oe_n_reg <= 1'b1;
			timer_out_pin <= 1'b0;
		end
		else
		begin
			pin_reg <= pin_next;
			oe_n_reg <= oe_n_next;
			timer_out_pin <= pin_next ^ (cfg.out_invert && !oe_n_next); // RULE_12
		end
	end

	assign timer_out_oe_n = oe_n_reg;
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

endmodule

// [core/ptimer_pkg.sv]
package ptimer_pkg;

	// register byte addresses on the apb bus
	localparam logic [7:0] ADDR_CTRL0 = 8'h00;
	localparam logic [7:0] ADDR_MODE_CTRL = 8'h04;
	localparam logic [7:0] ADDR_CNT_LOW = 8'h08;
	localparam logic [7:0] ADDR_CNT_HIGH = 8'h0c;
	localparam logic [7:0] ADDR_CMPA_LOW = 8'h10;
	localparam logic [7:0] ADDR_CMPA_HIGH = 8'h14;
	localparam logic [7:0] ADDR_CMPP_LOW = 8'h18;
	localparam logic [7:0] ADDR_CMPP_HIGH = 8'h1c;
	localparam logic [7:0] ADDR_PRESCALE = 8'h20;

	// field positions
	localparam int CTRL0_ON_BIT = 3;
	localparam int CTRL0_PAUSE_BIT = 7;
	localparam int MODE_CLEAR_BIT = 0;
	localparam int MODE_RSVD_BIT = 1;
	localparam int MODE_INVERT_BIT = 2;
	localparam int MODE_LEVEL_BIT = 3;
	localparam int MODE_PIN_LSB = 4;
	localparam int MODE_OP_LSB = 6;

	// widths and reset values
	localparam int CNT_W = 10;
	localparam int PRESCALE_W = 16;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [9:0] CNT_RESET = 10'h000;
	localparam logic [9:0] CNT_MAX = 10'h3ff;
	localparam logic [15:0] PRESCALE_RESET = 16'h0000;

	// operating modes
	localparam logic [1:0] OP_COMPARE = 2'h0;
	localparam logic [1:0] OP_UNDEF = 2'h1;
	localparam logic [1:0] OP_PWM = 2'h2;
	localparam logic [1:0] OP_TIMER = 2'h3;

	// pin functions
	localparam logic [1:0] PIN_00 = 2'h0;
	localparam logic [1:0] PIN_01 = 2'h1;
	localparam logic [1:0] PIN_10 = 2'h2;
	localparam logic [1:0] PIN_11 = 2'h3;

	// decoded control fields
	typedef struct packed {
		logic [1:0] op_mode_sel;
		logic [1:0] pin_func_sel;
		logic out_level_ctrl;
		logic out_invert;
		logic clear_source_sel;
	} mode_cfg_s;

	// compare events from the counter
	typedef struct packed {
		logic match_a;
		logic match_p;
		logic overflow;
	} cnt_event_s;

	// counter run state
	typedef enum logic [2:0] {
		RUN_OFF = 3'b001,
		RUN_ON = 3'b010,
		RUN_PAUSE = 3'b100
	} run_state_e;

endpackage

// [core/timer_counter10.sv]
`timescale 1ns/1ns
module timer_counter10
	import ptimer_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic tick,
	input wire logic start,
	input wire logic run,
	input wire logic [1:0] op_mode,
	input wire logic clear_source_sel,
	input wire logic [CNT_W-1:0] compare_a_value,
	input wire logic [CNT_W-1:0] compare_p_value,
	// state
	output logic [CNT_W-1:0] count,
	output cnt_event_s events
);

	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	cnt_event_s events_reg;
	cnt_event_s events_next;
	logic clr;

	// compare, clear and count once per tick
	always_comb
	begin
		events_next = '0;
		clr = 1'b0;
		count_next = count_reg;
		if (start)
			count_next = CNT_RESET; // RULE_21
		else if (run && tick)
		begin
			events_next.match_a = (count_reg == compare_a_value); // RULE_22
			events_next.match_p = (count_reg == compare_p_value); // RULE_22
			events_next.overflow = (count_reg == CNT_MAX);
			// a zero compare P gives the full 1024-count period
			if (op_mode == OP_PWM)
				clr = (compare_p_value != CNT_RESET) ? events_next.match_p : events_next.overflow; // RULE_16
			else if (clear_source_sel)
				clr = events_next.match_a; // RULE_14
			else
				clr = (events_next.match_p && compare_p_value != CNT_RESET) ||
					(events_next.overflow && compare_p_value == CNT_RESET); // RULE_14 RULE_15
			count_next = clr ? CNT_RESET : CNT_W'(count_reg + 1'b1);
		end
	end

	// register counter and events
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_reg <= CNT_RESET;
			events_reg <= '0;
		end
		else
		begin
			count_reg <= count_next;
			events_reg <= events_next;
		end
	end

	assign count = count_reg;
	assign events = events_reg;

endmodule

// [core/timer_tick_gen.sv]
`timescale 1ns/1ns
module timer_tick_gen
	import ptimer_pkg::*;
#(
	parameter int W = PRESCALE_W
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic [W-1:0] divide,
	// output tick
	output logic tick
);

	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;
	logic tick_reg;
	logic tick_next;

	// divide pclk by divide+1 into one-cycle ticks
	always_comb
	begin
		tick_next = (count_reg == divide);
		count_next = tick_next ? '0 : W'(count_reg + 1'b1);
	end

	// register the divider
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_reg <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;

endmodule

// [verif/periodic_timer_props.sv]
`timescale 1ns/1ns
module periodic_timer_props
	import ptimer_pkg::*;
(
	// apb side
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pin
	input wire logic timer_out_pin,
	input wire logic timer_out_oe_n
);
	logic [1:0] mode_reg;
	logic [1:0] mode_next;
	logic rd_ok;
	logic take;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////
	// mode field as last written by software
	always_comb
	begin
		mode_next = mode_reg;
		if (psel && penable && pready && pwrite && paddr == ADDR_MODE_CTRL)
			mode_next = pwdata[7:6];
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode_reg <= 2'h0;
		else
			mode_reg <= mode_next;
	end
	// request qualifiers
	assign rd_ok = psel && penable && pready && !pwrite;
	assign take = psel && penable && !pready;
	////////////////////////////////////////////////////////////
	ready_wait_a: assert property (take |=> pready) else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
	ready_cause_a: assert property (pready |-> psel && penable) else $error("pready unasked");
	err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
	unmapped_err_a: assert property (take && paddr > ADDR_PRESCALE |=> pslverr) else $error("no pslverr");
	mapped_ok_a: assert property (take && paddr <= ADDR_PRESCALE && paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("bad pslverr");
	high_zero_a: assert property (rd_ok && (paddr == ADDR_CNT_HIGH || paddr == ADDR_CMPA_HIGH
		|| paddr == ADDR_CMPP_HIGH) |-> prdata[31:2] == 30'h0) else $error("high bits set");
	byte_zero_a: assert property (rd_ok && paddr != ADDR_PRESCALE |-> prdata[31:8] == 24'h0)
		else $error("upper bits set");
	timer_float_a: assert property ((mode_reg == OP_TIMER) [*3] |-> timer_out_oe_n) else $error("pin driven");
	compare_drive_a: assert property ((mode_reg == OP_COMPARE) [*3] |-> !timer_out_oe_n)
		else $error("pin idle");
	// main scenarios
	cover property (rd_ok);
	cover property (pslverr);
	cover property (mode_reg == OP_TIMER && timer_out_oe_n);
	cover property ($rose(timer_out_pin));
endmodule

// [verif/periodic_timer_test.sv]
`timescale 1ns/1ns
module periodic_timer_test
	import ptimer_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic timer_out_pin;
	logic timer_out_oe_n;
	int fail_count = 0;
	int checks_done = 0;
	logic [31:0] q;
	logic e;
	int i;
	logic [7:0] rst_a [7] = '{ADDR_MODE_CTRL, ADDR_CNT_LOW, ADDR_CNT_HIGH, ADDR_CMPA_LOW,
		ADDR_CMPA_HIGH, ADDR_CMPP_LOW, ADDR_CMPP_HIGH};
	// mode byte, pin soon after start, pin after match a; bit i of early and late is scenario i
	logic [7:0] md [11] = '{8'h20, 8'h18, 8'h38, 8'h10, 8'h08, 8'h24, 8'ha8, 8'h88, 8'h98, 8'h78, 8'hb8};
	logic [10:0] early = 11'h576;
	logic [10:0] late = 11'h111;
	////////////////////////////////////////////////////////////
	periodic_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_out_pin(timer_out_pin), .timer_out_oe_n(timer_out_oe_n));
	// 20 mhz clock
	initial
	begin
		forever #25 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] x, input logic [31:0] got);
		checks_done++;
		if (got !== x)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, x, got);
		end
	endtask
	// one apb transfer, then one idle edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic er);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		if (n == 20)
			chk("pready", 32'h1, 32'h0);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic er;
		xfer(1'b1, a, d, r, er);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic er;
		xfer(1'b0, a, 32'h0, r, er);
		chk("prdata", x, r);
		chk("pslverr", 32'h0, {31'h0, er});
	endtask
	// restart the counter and watch its low byte stay within a bound
	task automatic bound(input logic [7:0] m, input logic [31:0] lim);
		logic [31:0] r;
		logic er;
		wr(ADDR_CTRL0, 32'h00);
		wr(ADDR_MODE_CTRL, {24'h0, m});
		wr(ADDR_CTRL0, 32'h08);
		repeat (30)
		begin
			xfer(1'b0, ADDR_CNT_LOW, 32'h0, r, er);
			chk("count bound", 32'h1, {31'h0, r <= lim});
		end
	endtask
	////////////////////////////////////////////////////////////
	// watchdog
	initial
	begin
		repeat (30000) @(posedge pclk);
		fail_count++;
		test_done();
	end
	// main sequence
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rst_a[k]) rd(rst_a[k], 32'h0);
		chk("oe_n", 32'h0, {31'h0, timer_out_oe_n});
		$display("test reset done");
		wr(ADDR_CMPA_LOW, 32'hff);
		wr(ADDR_CMPA_HIGH, 32'hff);
		wr(ADDR_CMPP_LOW, 32'h5a);
		wr(ADDR_CMPP_HIGH, 32'hfe);
		rd(ADDR_CMPA_LOW, 32'hff);
		rd(ADDR_CMPA_HIGH, 32'h03);
		rd(ADDR_CMPP_LOW, 32'h5a);
		rd(ADDR_CMPP_HIGH, 32'h02);
		wr(ADDR_CNT_LOW, 32'h55);
		rd(ADDR_CNT_LOW, 32'h00);
		xfer(1'b0, 8'h40, 32'h0, q, e);
		chk("unmapped", 32'h1, {31'h0, e});
		wr(ADDR_MODE_CTRL, 32'hfd);
		rd(ADDR_MODE_CTRL, 32'hfd);
		repeat (3) @(posedge pclk);
		chk("oe_n", 32'h1, {31'h0, timer_out_oe_n});
		$display("test regs done");
		wr(ADDR_PRESCALE, 32'h0);
		wr(ADDR_CMPA_HIGH, 32'h0);
		wr(ADDR_CMPA_LOW, 32'h28);
		wr(ADDR_CMPP_HIGH, 32'h0);
		wr(ADDR_CMPP_LOW, 32'h0);
		for (i = 0; i < 11; i++)
		begin
			wr(ADDR_CTRL0, 32'h00);
			wr(ADDR_MODE_CTRL, {24'h0, md[i]});
			wr(ADDR_CTRL0, 32'h08);
			repeat (3) @(posedge pclk);
			chk("pin start", {31'h0, early[i]}, {31'h0, timer_out_pin});
			repeat (60) @(posedge pclk);
			chk("pin match", {31'h0, late[i]}, {31'h0, timer_out_pin});
			// pin released in the two modes whose low mode bit is set
			chk("oe_n", {31'h0, md[i][MODE_OP_LSB]}, {31'h0, timer_out_oe_n});
		end
		rd(ADDR_CTRL0, 32'h00);
		$display("test pin done");
		bound(8'h01, 32'h28);
		wr(ADDR_CMPP_LOW, 32'h14);
		bound(8'h00, 32'h14);
		wr(ADDR_CTRL0, 32'h00);
		wr(ADDR_CMPP_LOW, 32'h0);
		wr(ADDR_CTRL0, 32'h08);
		repeat (300) @(posedge pclk);
		rd(ADDR_CNT_HIGH, 32'h01);
		wr(ADDR_CTRL0, 32'h00);
		xfer(1'b0, ADDR_CNT_LOW, 32'h0, q, e);
		repeat (20) @(posedge pclk);
		rd(ADDR_CNT_LOW, q);
		$display("test count done");
		test_done();
	end
endmodule
bind periodic_timer periodic_timer_props props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .timer_out_pin(timer_out_pin), .timer_out_oe_n(timer_out_oe_n));
